//--- rtl/ebmc_mode_control.sv
// state controller for standby, charge and active cycling
`timescale 1ns/1ns
module ebmc_mode_control
    import ebmc_pkg::*;
#(
    parameter bit TWO_WIRE_VARIANT = 1'b1  // 1: two-wire bus part, 0: four-wire part
)
(
    input  wire logic       clk,             // 20 MHz internal clock
    input  wire logic       resetn,          // asynchronous, active low
    input  wire logic       reg_wr,          // one-cycle register write strobe
    input  wire logic [7:0] reg_addr,        // register address
    input  wire logic [7:0] reg_wdata,       // register write data
    input  wire logic       cycle_trigger,   // auto mode trigger pin level
    input  wire logic       cap_below_target,// capacitor reading under charge target
    input  wire logic       load_idle,       // load gone quiet, ends short auto pulse
    output logic            charge_en,       // battery-to-capacitor converter on
    output logic            regulated_en,    // regulated_output converter on
    output logic            ready,           // ready indication
    output logic            opt_clear,       // one-cycle optimizer clear pulse
    output logic            auto_enable,     // auto mode enable bit state
    output logic [1:0]      state_code       // current state
);

    // ***********************************************************
    // registers and combinational signals
    // ***********************************************************
    logic        on_demand_en;   // mode command bit 0
    logic        continuous_en;  // mode command bit 1
    logic        force_act;      // mode command bit 2
    logic        auto_busy;      // auto cycle in progress
    logic        auto_long;      // trigger still held at activation
    logic        trig_prev;      // last trigger level for edge find
    ebmc_state_t state;          // state register
    ebmc_state_t next_state;     // combinational next state

    logic        wr_mode;        // write to mode command
    logic        wr_auto;        // write to auto trigger setting
    logic        trig_rise;      // trigger rising edge
    logic        any_mode;       // some mode keeps the device out of standby

    assign wr_mode   = reg_wr && (reg_addr == EBMC_MODE_COMMAND_ADDR);
    assign wr_auto   = reg_wr && (reg_addr == EBMC_AUTO_TRIGGER_ADDR);
    assign trig_rise = cycle_trigger && !trig_prev;
    assign any_mode  = on_demand_en || continuous_en || force_act || auto_busy;

    // ***********************************************************
    // mode command register
    // ***********************************************************
    // write only; bits hold until rewritten
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            on_demand_en  <= EBMC_MODE_RESET[EBMC_BIT_ON_DEMAND];
            continuous_en <= EBMC_MODE_RESET[EBMC_BIT_CONTINUOUS];
            force_act     <= EBMC_MODE_RESET[EBMC_BIT_FORCE_ACT];
        end
        else if (wr_mode)
        begin
            on_demand_en  <= reg_wdata[EBMC_BIT_ON_DEMAND];
            continuous_en <= reg_wdata[EBMC_BIT_CONTINUOUS];
            force_act     <= reg_wdata[EBMC_BIT_FORCE_ACT];
        end
    end

    // optimizer clear: a one only ever pulses, a zero does nothing
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            opt_clear <= 1'b0;
        else
            opt_clear <= wr_mode && reg_wdata[EBMC_BIT_OPT_RESET];
    end

    // ***********************************************************
    // auto mode enable
    // ***********************************************************
    // reset value depends on variant; four-wire part refuses a one
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            auto_enable <= TWO_WIRE_VARIANT;
        else if (wr_auto)
            auto_enable <= TWO_WIRE_VARIANT && reg_wdata[EBMC_BIT_AUTO_EN];
    end

    // ***********************************************************
    // trigger edge and auto cycle tracking
    // ***********************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            trig_prev <= 1'b0;
        else
            trig_prev <= cycle_trigger;
    end

    // a cycle runs from the trigger edge until the active state ends;
    // a long pulse ends on trigger low, a short one on load going idle
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            auto_busy <= 1'b0;
            auto_long <= 1'b0;
        end
        else if (!auto_busy)
        begin
            auto_busy <= auto_enable && trig_rise && (state == EBMC_STANDBY);
            auto_long <= 1'b0;
        end
        else if (state == EBMC_CHARGE && next_state == EBMC_ACTIVE)
        begin
            auto_long <= cycle_trigger;  // low during charge counts as short pulse
        end
        else if (state == EBMC_ACTIVE)
        begin
            // disabling auto mode also drops a cycle in flight
            if (!auto_enable || (auto_long ? !cycle_trigger : load_idle))
                auto_busy <= 1'b0;
        end
        else if (!auto_enable)
        begin
            auto_busy <= 1'b0;
        end
    end

    // ***********************************************************
    // state machine
    // ***********************************************************
    always_comb
    begin
        next_state = state;
        unique case (state)
            EBMC_STANDBY:
            begin
                if (force_act)
                    next_state = EBMC_ACTIVE;
                else if (any_mode)
                    next_state = EBMC_CHARGE;
            end
            EBMC_CHARGE:
            begin
                if (!any_mode)
                    next_state = EBMC_STANDBY;
                else if (force_act)
                    next_state = EBMC_ACTIVE;
                else if (!cap_below_target)
                begin
                    // target met: auto and on-demand go active,
                    // continuous idles in standby-like hold
                    if (auto_busy || on_demand_en)
                        next_state = EBMC_ACTIVE;
                    else
                        next_state = EBMC_STANDBY;
                end
            end
            EBMC_ACTIVE:
            begin
                if (!any_mode)
                    next_state = EBMC_STANDBY;
                else if (continuous_en && !force_act)
                    next_state = EBMC_CHARGE;
                else if (!force_act && !on_demand_en && !auto_busy)
                    next_state = EBMC_STANDBY;
            end
            default:
                next_state = EBMC_STANDBY;
        endcase
        // continuous idle: leave standby only when capacitor sagged
        if (state == EBMC_STANDBY && !force_act && !auto_busy && !on_demand_en
            && continuous_en && !cap_below_target && ready)
            next_state = EBMC_STANDBY;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            state <= EBMC_STANDBY;
        else
            state <= next_state;
    end

    // ***********************************************************
    // outputs, all registered
    // ***********************************************************
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            charge_en    <= 1'b0;
            regulated_en <= 1'b0;
            state_code   <= EBMC_STANDBY;
        end
        else
        begin
            charge_en    <= (next_state == EBMC_CHARGE);
            regulated_en <= (next_state == EBMC_ACTIVE);
            state_code   <= next_state;
        end
    end

    // ready: capacitor at target while a mode holds, or output regulating
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ready <= 1'b0;
        else if (!any_mode)
            ready <= 1'b0;
        else if (next_state == EBMC_ACTIVE)
            ready <= 1'b1;
        else if (state == EBMC_CHARGE && !cap_below_target)
            ready <= 1'b1;
        else if (cap_below_target)
            ready <= 1'b0;
    end

endmodule : ebmc_mode_control

//--- rtl/ebmc_pkg.sv
// package of constants and types for the energy buffer mode control
package ebmc_pkg;

    // ***********************************************************
    // register map
    // ***********************************************************
    localparam logic [7:0] EBMC_MODE_COMMAND_ADDR  = 8'h08;  // write only
    localparam logic [7:0] EBMC_AUTO_TRIGGER_ADDR  = 8'h11;  // auto enable in bit 7

    // ***********************************************************
    // field positions
    // ***********************************************************
    localparam int EBMC_BIT_ON_DEMAND  = 0;  // enable on-demand mode
    localparam int EBMC_BIT_CONTINUOUS = 1;  // enable continuous mode
    localparam int EBMC_BIT_FORCE_ACT  = 2;  // force active state
    localparam int EBMC_BIT_OPT_RESET  = 3;  // reset optimizer result
    localparam int EBMC_BIT_AUTO_EN    = 7;  // pin-triggered auto mode

    // ***********************************************************
    // reset values
    // ***********************************************************
    localparam logic [3:0] EBMC_MODE_RESET  = 4'h0;  // all modes off
    localparam logic [6:0] EBMC_AUTO_TRIGGER_SETTING_RESET  = 7'h00; // other setting bits

    // device states; gray codes along standby-charge-active
    typedef enum logic [1:0] {
        EBMC_STANDBY = 2'b00,
        EBMC_CHARGE  = 2'b01,
        EBMC_ACTIVE  = 2'b11
    } ebmc_state_t;

endpackage : ebmc_pkg

//--- tb/ebmc_mode_control_assertions.sv
// checker of the mode control ports
`timescale 1ns/1ns
module ebmc_mode_control_assertions
    import ebmc_pkg::*;
#(parameter bit TWO_WIRE_VARIANT = 1'b1)
(
    input wire logic       clk, resetn, reg_wr, cycle_trigger, cap_below_target, load_idle,
    input wire logic [7:0] reg_addr, reg_wdata,
    input wire logic       charge_en, regulated_en, ready, opt_clear, auto_enable,
    input wire logic [1:0] state_code
);
    // decoded write requests; outputs follow one or two edges later
    wire logic mw       = reg_wr && reg_addr == 8'h08;
    wire logic opt_req  = mw && reg_wdata[3];
    wire logic auto_bit = reg_wdata[7] & TWO_WIRE_VARIANT;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    AST_OPT_PULSE: assert property (opt_req |=> opt_clear) else $error("no clear");
    AST_OPT_CAUSE: assert property (opt_clear |-> $past(opt_req)) else $error("stray");
    AST_CODE_LEGAL: assert property (state_code != 2'b10) else $error("bad state");
    AST_STANDBY_IDLE: assert property (state_code == EBMC_STANDBY |-> !charge_en && !regulated_en)
        else $error("standby busy");
    AST_CHARGE_ONLY: assert property (charge_en |-> state_code == EBMC_CHARGE)
        else $error("charge out of state");
    AST_ACTIVE_ONLY: assert property (regulated_en |-> state_code == EBMC_ACTIVE)
        else $error("output out of state");
    AST_FORCE_ACTIVE: assert property (mw && reg_wdata[2] |-> ##2 state_code == EBMC_ACTIVE)
        else $error("no force");
    AST_AUTO_WRITE: assert property (reg_wr && reg_addr == 8'h11 |=> auto_enable == $past(auto_bit))
        else $error("auto bit");
    AST_FOUR_WIRE: assert property (!TWO_WIRE_VARIANT |-> !auto_enable) else $error("auto set");
    AST_ALL_CLEAR: assert property (mw && reg_wdata[2:0] == 3'b000 && !auto_enable
        |-> ##2 state_code == EBMC_STANDBY) else $error("no standby");
    cover property (state_code == EBMC_ACTIVE && ready);
    cover property (opt_clear);
    cover property ($rose(charge_en));
endmodule : ebmc_mode_control_assertions
bind ebmc_mode_control ebmc_mode_control_assertions #(.TWO_WIRE_VARIANT(TWO_WIRE_VARIANT)) chk (
    .clk(clk), .resetn(resetn), .reg_wr(reg_wr), .cycle_trigger(cycle_trigger),
    .cap_below_target(cap_below_target), .load_idle(load_idle), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .charge_en(charge_en), .regulated_en(regulated_en), .ready(ready),
    .opt_clear(opt_clear), .auto_enable(auto_enable), .state_code(state_code));

//--- tb/ebmc_host_model.sv
// host model writing the mode registers and driving the trigger pin
`timescale 1ns/1ns
module ebmc_host_model
(
    input  wire logic clk,
    output logic      reg_wr, cycle_trigger,
    output logic [7:0] reg_addr, reg_wdata
);
    initial
    begin
        reg_wr        = 1'b0;
        cycle_trigger = 1'b0;
        reg_addr      = 8'h00;
        reg_wdata     = 8'h00;
    end
    // one strobe across one rising edge; data garbled after release
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(negedge clk);
        reg_wr    = 1'b0;
        reg_wdata = ~d;
    endtask : wr
    // trigger pin level change off the sampling edge
    task automatic trig(input logic v);
        @(negedge clk);
        cycle_trigger = v;
    endtask : trig
endmodule : ebmc_host_model

//--- tb/testbench.sv
// self-checking testbench of the mode control block
`timescale 1ns/1ns
module testbench;
    import ebmc_pkg::*;
    logic       clk = 1'b0, resetn = 1'b0, cap_below_target = 1'b0, load_idle = 1'b0;
    logic       reg_wr, cycle_trigger, charge_en, regulated_en, ready, opt_clear;
    logic       auto_enable, auto_four;
    logic [7:0] reg_addr, reg_wdata;
    logic [1:0] state_code;
    int         err_total = 0, total_checks = 0, cycles = 0;
    always #25 clk = ~clk;
    ebmc_host_model host (.clk(clk), .reg_wr(reg_wr), .cycle_trigger(cycle_trigger),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    ebmc_mode_control dut (.clk(clk), .resetn(resetn), .reg_wr(reg_wr), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .cycle_trigger(cycle_trigger),
        .cap_below_target(cap_below_target), .load_idle(load_idle), .charge_en(charge_en),
        .regulated_en(regulated_en), .ready(ready), .opt_clear(opt_clear),
        .auto_enable(auto_enable), .state_code(state_code));
    // four-wire part shares the bus; only its auto bit is watched
    ebmc_mode_control #(.TWO_WIRE_VARIANT(1'b0)) dut_four (.clk(clk), .resetn(resetn),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .cycle_trigger(cycle_trigger), .cap_below_target(cap_below_target),
        .load_idle(load_idle), .charge_en(), .regulated_en(), .ready(), .opt_clear(),
        .auto_enable(auto_four), .state_code());
    task automatic chk(input logic [1:0] seen, input logic [1:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %0t: got %b want %b", $time, seen, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // hang guard, far above the roughly 63 cycles the tests need
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_total++;
            give_verdict();
        end
    end
    initial
    begin
        idle(3);
        resetn = 1'b1;
        chk(state_code, EBMC_STANDBY);
        chk({charge_en, ready}, 2'b00);
        chk({auto_enable, auto_four}, 2'b10);
        host.wr(8'h11, 8'h00);
        chk({auto_enable, auto_four}, 2'b00);
        $display("reset test done");
        cap_below_target = 1'b1;
        host.wr(8'h08, 8'h02);
        idle(2);
        chk(state_code, EBMC_CHARGE);
        chk({charge_en, regulated_en}, 2'b10);
        cap_below_target = 1'b0;
        idle(2);
        chk(state_code, EBMC_STANDBY);
        chk({charge_en, ready}, 2'b01);
        cap_below_target = 1'b1;
        idle(2);
        chk(state_code, EBMC_CHARGE);
        cap_below_target = 1'b0;
        host.wr(8'h08, 8'h06);
        idle(2);
        chk(state_code, EBMC_ACTIVE);
        chk({regulated_en, charge_en}, 2'b10);
        cap_below_target = 1'b1;
        host.wr(8'h08, 8'h02);
        idle(2);
        chk(state_code, EBMC_CHARGE);
        cap_below_target = 1'b0;
        host.wr(8'h08, 8'h04);
        idle(2);
        chk(state_code, EBMC_ACTIVE);
        host.wr(8'h08, 8'h00);
        idle(2);
        chk(state_code, EBMC_STANDBY);
        $display("continuous test done");
        cap_below_target = 1'b1;
        host.wr(8'h08, 8'h01);
        idle(2);
        chk(state_code, EBMC_CHARGE);
        cap_below_target = 1'b0;
        idle(2);
        chk(state_code, EBMC_ACTIVE);
        host.wr(8'h08, 8'h08);
        chk({1'b0, opt_clear}, 2'b01);
        idle(1);
        chk({1'b0, opt_clear}, 2'b00);
        chk(state_code, EBMC_STANDBY);
        host.wr(8'h09, 8'h07);
        idle(2);
        chk(state_code, EBMC_STANDBY);
        $display("on-demand test done");
        host.wr(8'h11, 8'h80);
        chk({auto_enable, auto_four}, 2'b10);
        cap_below_target = 1'b1;
        host.trig(1'b1);
        idle(3);
        chk({charge_en, ready}, 2'b10);
        cap_below_target = 1'b0;
        idle(2);
        chk({regulated_en, ready}, 2'b11);
        host.trig(1'b0);
        idle(3);
        chk(state_code, EBMC_STANDBY);
        cap_below_target = 1'b1;
        host.trig(1'b1);
        host.trig(1'b0);
        idle(3);
        chk({charge_en, regulated_en}, 2'b10);
        cap_below_target = 1'b0;
        idle(2);
        chk({regulated_en, ready}, 2'b11);
        load_idle = 1'b1;
        idle(2);
        chk(state_code, EBMC_STANDBY);
        chk({regulated_en, ready}, 2'b00);
        load_idle = 1'b0;
        $display("auto test done");
        give_verdict();
    end
endmodule : testbench
